/* File: ext_bus_ctrl.sv */
// External bus state controller: four chip-select spaces, DRAM/SDRAM/pseudo-SRAM/basic
// cycles, line fill, refresh timer and bus arbitration.
// Assumes all inputs synchronous to clk; the pad ring resolves pins from the enables.
`timescale 1ns/1ns
// Overview of operation
// - Drive 27-bit address; top two bits pick one of four 32 MB spaces.
// - Exactly one active-low space select per access, chosen by address bits 26 and 25; CBR refresh asserts all four.
// - Each space has its own memory type and matching control strobes.
// - Each space has its own bus width 8/16/32 and wait-state count.
// - 16-bit spaces use low sixteen data lines, 8-bit spaces low eight.
// - Narrow access to a 32-bit space uses the lane set by low address.
// - Address marks access cacheable or cache-through; through goes at requested size.
// - Cacheable read miss fetches a 16-byte line as four 4-byte reads.
// - Writes are write-through: every write goes out on the bus.
// - CBR auto-refresh and self-refresh, interval from counter and clock select.
// - Refresh counter doubles as timer; compare match raises an interrupt.
// - DRAM: row/column multiplexed, burst reads, page mode within a transfer.
// - DRAM: a precharge cycle follows each access for row-strobe precharge.
// - SDRAM: row/column multiplexed, burst read, single write, bank active option.
// - Total master: release the bus on an external release request.
// - Partial-share master: only space 2 needs arbitration.
// - Slave: request bus use, access only after permission returns.
// - Basic interface: start strobe one cycle, with the address.
// - DRAM/SDRAM: start strobe one cycle, with the column address; pseudo-SRAM: with the full address.
// - Released bus: address, strobe, direction become inputs; rest float.
// - Lane strobes act as CAS, DQM, WE or byte-write flag by type.
// - Direction signal marks read or write for every access.
// - Release request in and grant out; or bus request out and enable in.
module ext_bus_ctrl import ebsc_pkg::*; (
  // System
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Internal access port
  input wire logic req,
  input wire logic [28:0] req_addr,
  input wire logic req_we,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic req_ack,
  output logic req_err,
  output logic [31:0] req_rdata,
  // Address, data, start strobe and direction pins
  output logic [26:0] addr_out,
  output logic addr_oe,
  input wire logic [26:0] addr_in,
  output logic [31:0] data_out,
  output logic data_oe,
  input wire logic [31:0] data_in,
  output logic cycle_start_strobe_n,
  input wire logic cycle_start_strobe_in_n,
  output logic rdwr_n,
  input wire logic rdwr_in_n,
  // Memory strobes, floated together by ctrl_oe
  output logic [3:0] space_select_n,
  output logic ras_n,
  output logic cas_n,
  output logic rd_n,
  output logic [3:0] lane_strobe_n,
  output logic ctrl_oe,
  output logic precharge_cycle,
  input wire logic wait_n,
  // Arbitration, refresh and timer
  input wire logic bus_release_request_in,
  output logic bus_grant_out,
  output logic bus_use_request_out,
  input wire logic bus_use_enable_in,
  output logic cke,
  output logic refresh_compare_match_irq
);
  typedef enum {ST_IDLE, ST_ARB, ST_GO, ST_ROW, ST_COL, ST_WAIT, ST_PRE, ST_RF_CAS,
    ST_RF_RAS, ST_REL} state_t;
  typedef struct packed {
    state_t st;
    logic [3:0][15:0] cfg;
    logic [15:0] mode, cnt, cmp;
    logic cmf, ref_pend, busy, we, row_open;
    logic [3:0] done, wcnt;
    logic [7:0] presc;
    logic [26:0] cur_addr;
    logic [17:0] open_row;
    logic [31:0] wdata, acc, rdata, dout;
    logic [2:0] ubytes, bleft, units;
    logic [15:0] rrdata;
    logic [26:0] aout;
    logic ready, ack, err, aoe, doe, cstart, rw, coe, ras, cas, rd, pre, grant, use_req, irq, cke;
    logic [3:0] sel, lane;
  } bsc_state_t;

  bsc_state_t s_reg, s_next;
  logic [1:0] sp, rsp, lane_lo;
  logic [15:0] c, rv;
  mem_type_t mt;
  arb_mode_t arb;
  logic [2:0] wb, bpb, rem;
  logic [4:0] sh;
  logic [31:0] msk, chunk;
  logic [3:0] lmask;
  logic tick, dram_like, row_hit;

  always_comb begin
    s_next = s_reg;
    sp = s_reg.cur_addr[SPACE_HI:SPACE_LO];
    c = s_reg.cfg[sp];
    mt = mem_type_t'(c[CFG_TYPE_LSB +: 3]);
    arb = arb_mode_t'(s_reg.mode[MODE_ARB_LSB +: 2]);
    rsp = req_addr[SPACE_HI:SPACE_LO];
    case (c[CFG_WIDTH_LSB +: 2])
      WID_8: wb = 3'h1;
      WID_16: wb = 3'h2;
      default: wb = 3'h4;
    endcase
    bpb = (s_reg.ubytes < wb) ? s_reg.ubytes : wb;
    rem = s_reg.bleft - bpb;
    // Narrow spaces sit on the low lanes; a 32-bit space uses the addressed lane
    lane_lo = (wb == 3'h4) ? 2'(3'h4 - bpb - {1'b0, s_reg.cur_addr[1:0]}) : 2'h0;
    sh = {lane_lo, 3'b000};
    msk = (bpb == 3'h1) ? 32'h0000_00ff : (bpb == 3'h2) ? 32'h0000_ffff : 32'hffff_ffff;
    chunk = (s_reg.wdata >> {rem, 3'b000}) & msk;
    lmask = ((bpb == 3'h1) ? 4'h1 : (bpb == 3'h2) ? 4'h3 : 4'hf) << lane_lo;
    dram_like = (mt == MEM_DRAM) || (mt == MEM_SDRAM);
    row_hit = s_reg.row_open && (s_reg.open_row == s_reg.cur_addr[26:COL_BITS]);
    rv = 16'h0000;
    s_next.ack = 1'b0;
    s_next.err = 1'b0;
    s_next.cstart = 1'b1;
    s_next.pre = 1'b0;
    s_next.rrdata = 16'h0000;

    // Refresh counter, also a free interval timer
    s_next.presc = s_reg.presc + 8'h01;
    tick = &(s_reg.presc | ~CKS_MASKS[s_reg.mode[MODE_CKS_LSB +: 2]]);
    if (tick) begin
      if (s_reg.cnt == s_reg.cmp) begin
        s_next.cnt = 16'h0000;
        s_next.cmf = 1'b1;
        s_next.ref_pend = s_reg.mode[MODE_REF_EN] && !s_reg.mode[MODE_SELF];
      end else begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end

    if (reg_wr) begin
      if (reg_addr < REG_MODE) begin
        s_next.cfg[reg_addr[3:2]] = reg_wdata;
        s_next.done[reg_addr[3:2]] = 1'b1;
      end else if (reg_addr == REG_MODE) begin
        s_next.mode = reg_wdata;
      end else if (reg_addr == REG_COUNT) begin
        s_next.cnt = reg_wdata;
      end else if (reg_addr == REG_COMPARE) begin
        s_next.cmp = reg_wdata;
      end else if (reg_addr == REG_STATUS) begin
        // Writing zero clears the match flag; a match in the same cycle wins
        s_next.cmf = s_next.cmf && (reg_wdata[0] || (tick && s_reg.cnt == s_reg.cmp));
      end
    end
    if (reg_rd) begin
      if (reg_addr < REG_MODE) begin
        rv = s_reg.cfg[reg_addr[3:2]];
      end else if (reg_addr == REG_MODE) begin
        rv = s_reg.mode;
      end else if (reg_addr == REG_COUNT) begin
        rv = s_reg.cnt;
      end else if (reg_addr == REG_COMPARE) begin
        rv = s_reg.cmp;
      end else if (reg_addr == REG_STATUS) begin
        rv = {10'h000, s_reg.busy, s_reg.done, s_reg.cmf};
      end
      s_next.rrdata = rv;
    end
    s_next.irq = s_next.cmf && s_next.mode[MODE_IRQ_EN];
    s_next.ras = s_next.ras; // held by the sequencer below
    s_next.cke = 1'b0;

    case (s_reg.st)
      ST_IDLE: begin
        if (req) begin
          s_next.busy = 1'b1;
          s_next.we = req_we;
          s_next.wdata = req_wdata;
          s_next.acc = 32'h0000_0000;
          if (!req_addr[CT_BIT] && !req_we) begin
            s_next.cur_addr = {req_addr[26:4], 4'h0};
            s_next.ubytes = UNIT_BYTES;
            s_next.units = FILL_UNITS;
          end else begin
            s_next.cur_addr = req_addr[26:0];
            s_next.ubytes = (req_size == 2'h0) ? 3'h1 : (req_size == 2'h1) ? 3'h2 : 3'h4;
            s_next.units = 3'h1;
          end
          s_next.bleft = s_next.ubytes;
          if (rsp != 2'h0 && !s_reg.done[rsp]) begin
            s_next.err = 1'b1;
            s_next.busy = 1'b0;
          end else if (arb == ARB_SLAVE || (arb == ARB_PARTIAL && rsp == SHARED_SPACE)) begin
            s_next.use_req = 1'b1;
            s_next.st = ST_ARB;
          end else begin
            s_next.st = ST_GO;
          end
        end else if (s_reg.ref_pend) begin
          s_next.ref_pend = 1'b0;
          s_next.sel = 4'h0;
          s_next.lane = 4'h0;
          s_next.cas = 1'b0;
          s_next.st = ST_RF_CAS;
        end else if (arb == ARB_TOTAL && bus_release_request_in) begin
          s_next.aoe = 1'b0;
          s_next.doe = 1'b0;
          s_next.coe = 1'b0;
          s_next.grant = 1'b1;
          s_next.st = ST_REL;
        end
      end
      ST_ARB: begin
        if (bus_use_enable_in) begin
          s_next.st = ST_GO;
        end
      end
      ST_GO: begin
        s_next.aoe = 1'b1;
        s_next.coe = 1'b1;
        s_next.doe = s_reg.we;
        s_next.rw = !s_reg.we;
        s_next.sel = ~(4'h1 << sp);
        if (mt == MEM_SDRAM && s_reg.row_open && !row_hit) begin
          s_next.st = ST_PRE;
        end else if ((dram_like && !row_hit) || mt == MEM_PSRAM) begin
          s_next.aout = 27'(s_reg.cur_addr[26:COL_BITS]);
          s_next.ras = 1'b0;
          s_next.st = ST_ROW;
        end else begin
          s_next.st = ST_COL;
        end
      end
      ST_ROW: begin
        s_next.ras = (mt == MEM_SDRAM) ? 1'b1 : 1'b0;
        s_next.st = ST_COL;
      end
      ST_COL: begin
        // Strobe roles per memory type
        s_next.lane = (s_reg.we || mt == MEM_DRAM || mt == MEM_SDRAM) ? ~lmask : 4'hf;
        s_next.cas = !((mt == MEM_SDRAM) || (mt == MEM_PSRAM && !s_reg.we));
        s_next.rd = s_reg.we || dram_like || mt == MEM_PSRAM;
        s_next.dout = chunk << sh;
        s_next.wcnt = c[CFG_WAIT_LSB +: 4];
        s_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (mt == MEM_SDRAM) begin
          s_next.cas = 1'b1;
        end
        if (s_reg.wcnt != 4'h0) begin
          s_next.wcnt = s_reg.wcnt - 4'h1;
        end else if (wait_n) begin
          s_next.acc = (s_reg.acc << {bpb, 3'b000}) | ((data_in >> sh) & msk);
          s_next.bleft = rem;
          s_next.lane = 4'hf;
          s_next.cas = 1'b1;
          s_next.rd = 1'b1;
          if (rem != 3'h0) begin
            s_next.cur_addr = s_reg.cur_addr + 27'(bpb);
            s_next.st = ST_COL;
          end else begin
            s_next.ack = 1'b1;
            s_next.rdata = s_next.acc;
            if (s_reg.units > 3'h1) begin
              s_next.units = s_reg.units - 3'h1;
              s_next.cur_addr = s_reg.cur_addr + 27'(bpb);
              s_next.bleft = s_reg.ubytes;
              s_next.acc = 32'h0000_0000;
              s_next.st = ST_COL;
            end else begin
              s_next.busy = 1'b0;
              s_next.use_req = 1'b0;
              s_next.doe = 1'b0;
              s_next.sel = 4'hf;
              s_next.st = ST_IDLE;
              if (mt == MEM_SDRAM && c[CFG_BANK_BIT]) begin
                s_next.row_open = 1'b1;
                s_next.open_row = s_reg.cur_addr[26:COL_BITS];
              end else if (dram_like || mt == MEM_PSRAM) begin
                s_next.st = ST_PRE;
              end
            end
          end
        end
      end
      ST_PRE: begin
        s_next.ras = 1'b1;
        s_next.cas = 1'b1;
        s_next.lane = 4'hf;
        s_next.pre = 1'b1;
        s_next.row_open = 1'b0;
        s_next.st = s_reg.busy ? ST_GO : ST_IDLE;
        s_next.sel = s_reg.busy ? s_reg.sel : 4'hf;
      end
      ST_RF_CAS: begin
        s_next.ras = 1'b0;
        s_next.st = ST_RF_RAS;
      end
      ST_RF_RAS: begin
        s_next.sel = 4'hf;
        s_next.st = ST_PRE;
      end
      ST_REL: begin
        if (!bus_release_request_in) begin
          s_next.grant = 1'b0;
          s_next.aoe = 1'b1;
          s_next.coe = 1'b1;
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    // Column phase: address and one-cycle start strobe together
    if (s_next.st == ST_COL) begin
      s_next.cstart = 1'b0;
      s_next.aout = dram_like ? 27'(s_next.cur_addr[COL_BITS-1:0]) : s_next.cur_addr;
    end
    s_next.cke = !s_next.mode[MODE_SELF];
    s_next.ready = (s_next.st == ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.cfg <= {4{CFG_RESET}};
      s_reg.mode <= MODE_RESET;
      s_reg.cmp <= COMPARE_RESET;
      s_reg.done <= DONE_RESET;
      s_reg.ready <= 1'b1;
      s_reg.aoe <= 1'b1;
      s_reg.coe <= 1'b1;
      s_reg.cstart <= 1'b1;
      s_reg.rw <= 1'b1;
      s_reg.ras <= 1'b1;
      s_reg.cas <= 1'b1;
      s_reg.rd <= 1'b1;
      s_reg.cke <= 1'b1;
      s_reg.sel <= 4'hf;
      s_reg.lane <= 4'hf;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rrdata;
  assign req_ready = s_reg.ready;
  assign req_ack = s_reg.ack;
  assign req_err = s_reg.err;
  assign req_rdata = s_reg.rdata;
  assign addr_out = s_reg.aout;
  assign addr_oe = s_reg.aoe;
  assign data_out = s_reg.dout;
  assign data_oe = s_reg.doe;
  assign cycle_start_strobe_n = s_reg.cstart;
  assign rdwr_n = s_reg.rw;
  assign space_select_n = s_reg.sel;
  assign ras_n = s_reg.ras;
  assign cas_n = s_reg.cas;
  assign rd_n = s_reg.rd;
  assign lane_strobe_n = s_reg.lane;
  assign ctrl_oe = s_reg.coe;
  assign precharge_cycle = s_reg.pre;
  assign bus_grant_out = s_reg.grant;
  assign bus_use_request_out = s_reg.use_req;
  assign cke = s_reg.cke;
  assign refresh_compare_match_irq = s_reg.irq;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_ONE_SELECT: assert property (s_reg.st == ST_COL |-> $onehot(~space_select_n))
    else $error("not exactly one space select in column phase");
  AST_SELECT_DECODE: assert property (
    s_reg.st == ST_COL |-> !space_select_n[s_reg.cur_addr[SPACE_HI:SPACE_LO]])
    else $error("space select does not match address bits");
  AST_STROBE_ONE: assert property (!cycle_start_strobe_n |=> cycle_start_strobe_n)
    else $error("start strobe longer than one cycle");
  AST_STROBE_COL: assert property (
    $fell(cycle_start_strobe_n) |-> s_reg.st == ST_COL && addr_oe && $past(s_next.st) == ST_COL)
    else $error("start strobe outside column phase");
  AST_NARROW_LANES: assert property (
    s_reg.st == ST_WAIT && s_reg.cfg[s_reg.cur_addr[SPACE_HI:SPACE_LO]][CFG_WIDTH_LSB +: 2] != 2'h2
    |-> lane_strobe_n[3:2] == 2'b11)
    else $error("narrow space used an upper lane");
  AST_RELEASED: assert property (bus_grant_out |-> !addr_oe && !data_oe && !ctrl_oe)
    else $error("pins driven while bus released");
  AST_SLAVE_WAIT: assert property (
    s_reg.mode[MODE_ARB_LSB +: 2] == 2'h2 && $rose(s_reg.st == ST_GO)
    |-> bus_use_request_out && $past(bus_use_enable_in))
    else $error("slave access started without permission");
  AST_PRECHARGE: assert property (
    s_reg.st == ST_PRE |-> ##1 precharge_cycle && ras_n)
    else $error("precharge cycle missing");
  AST_MATCH_IRQ: assert property (
    tick && s_reg.cnt == s_reg.cmp && s_reg.mode[MODE_IRQ_EN] && !reg_wr
    |=> s_reg.cmf && refresh_compare_match_irq)
    else $error("compare match did not raise interrupt");
  AST_SELF_CKE: assert property (s_reg.mode[MODE_SELF] |-> !cke)
    else $error("clock enable high in self-refresh");
endmodule

/* File: ebsc_pkg.sv */
// Constants, register map and types of the external bus state controller.
// Assumes a 50 MHz system clock and a 16-bit register port on 5 address bits.
package ebsc_pkg;
  typedef enum logic [2:0] {MEM_BASIC, MEM_DRAM, MEM_SDRAM, MEM_PSRAM, MEM_BROM} mem_type_t;
  typedef enum logic [1:0] {ARB_TOTAL, ARB_PARTIAL, ARB_SLAVE} arb_mode_t;
  localparam logic [4:0] REG_SPACE0 = 5'h00;
  localparam logic [4:0] REG_MODE = 5'h10;
  localparam logic [4:0] REG_COUNT = 5'h14;
  localparam logic [4:0] REG_COMPARE = 5'h18;
  localparam logic [4:0] REG_STATUS = 5'h1c;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_WIDTH_LSB = 3;
  localparam int CFG_WAIT_LSB = 5;
  localparam int CFG_BANK_BIT = 9;
  localparam int MODE_ARB_LSB = 0;
  localparam int MODE_REF_EN = 2;
  localparam int MODE_SELF = 3;
  localparam int MODE_CKS_LSB = 4;
  localparam int MODE_IRQ_EN = 6;
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [15:0] CFG_RESET = 16'h0070;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  localparam logic [3:0] DONE_RESET = 4'h1;
  localparam logic [3:0][7:0] CKS_MASKS = {8'hff, 8'h3f, 8'h0f, 8'h03};
  localparam int SPACE_HI = 26;
  localparam int SPACE_LO = 25;
  localparam int CT_BIT = 28;
  localparam int COL_BITS = 9;
  localparam logic [1:0] SHARED_SPACE = 2'h2;
  localparam logic [2:0] UNIT_BYTES = 3'h4;
  localparam logic [2:0] FILL_UNITS = 3'h4;
endpackage

/* File: ext_mem_model.sv */
// Word-store memory on the controller's external pins, answering as a basic-interface part.
// Assumes active-low selects and lane strobes, data pins resolved from data_oe by the bench.
`timescale 1ns/1ns
module ext_mem_model (
  // System
  input wire logic clk,
  // Pins from the controller
  input wire logic [26:0] addr_out,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic [3:0] space_select_n,
  input wire logic rd_n,
  input wire logic [3:0] lane_strobe_n,
  input wire logic ctrl_oe,
  // Stretch control from the bench
  input wire logic slow,
  // Answers to the controller
  output logic [31:0] data_in,
  output logic wait_n
);
  logic [31:0] mem [logic [25:0]];
  logic [31:0] last;
  logic [1:0] held;
  logic sel;
  logic [25:0] key;
  assign sel = ctrl_oe && (space_select_n != 4'hf);
  // Halfword key keeps 16-bit beats apart and bytes inside one halfword together
  assign key = addr_out[26:1];
  assign wait_n = !(slow && sel && (held != 2'h2));
  // Released data lines toggle every cycle so a stale value never looks valid
  always_comb begin
    if (sel && !rd_n) begin
      data_in = mem.exists(key) ? mem[key] : {5'h00, addr_out};
    end else begin
      data_in = ~last;
    end
  end
  always @(posedge clk) begin
    last <= data_in;
    held <= !sel ? 2'h0 : (held == 2'h2) ? held : held + 2'h1;
    if (sel && data_oe) begin
      if (!mem.exists(key)) mem[key] = {5'h00, addr_out};
      for (int i = 0; i < 4; i++) begin
        if (!lane_strobe_n[i]) mem[key][8*i +: 8] = data_out[8*i +: 8];
      end
    end
  end
endmodule

/* File: testbench.sv */
// Self-checking bench for ext_bus_ctrl with a word-store memory model on its pins.
// Assumes registered outputs settle within 1 ns after the rising clock edge.
`timescale 1ns/1ns
module testbench import ebsc_pkg::*;;
  logic clk, rstn, reg_wr, reg_rd, req, req_we, req_ready, req_ack, req_err, slow;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [28:0] req_addr;
  logic [1:0] req_size;
  logic [31:0] req_wdata, req_rdata, data_out, data_in, rdq;
  logic [26:0] addr_out;
  logic addr_oe, data_oe, cycle_start_strobe_n, rdwr_n, ras_n, cas_n, rd_n, ctrl_oe;
  logic precharge_cycle, wait_n, bus_release_request_in, bus_grant_out, dir_low;
  logic bus_use_request_out, bus_use_enable_in, cke, refresh_compare_match_irq;
  logic [3:0] space_select_n, lane_strobe_n, sel_seen, lanes;
  int err_total, comparisons, acks, errs, starts;

  ext_bus_ctrl ext_bus_ctrl_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req(req), .req_addr(req_addr), .req_we(req_we), .req_size(req_size),
    .req_wdata(req_wdata), .req_ready(req_ready), .req_ack(req_ack), .req_err(req_err),
    .req_rdata(req_rdata), .addr_out(addr_out), .addr_oe(addr_oe), .addr_in(27'h0000000),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .cycle_start_strobe_n(cycle_start_strobe_n), .cycle_start_strobe_in_n(1'b1),
    .rdwr_n(rdwr_n), .rdwr_in_n(1'b1), .space_select_n(space_select_n), .ras_n(ras_n),
    .cas_n(cas_n), .rd_n(rd_n), .lane_strobe_n(lane_strobe_n), .ctrl_oe(ctrl_oe),
    .precharge_cycle(precharge_cycle), .wait_n(wait_n),
    .bus_release_request_in(bus_release_request_in), .bus_grant_out(bus_grant_out),
    .bus_use_request_out(bus_use_request_out), .bus_use_enable_in(bus_use_enable_in),
    .cke(cke), .refresh_compare_match_irq(refresh_compare_match_irq));
  ext_mem_model ext_mem_model_i (.clk(clk), .addr_out(addr_out), .data_out(data_out),
    .data_oe(data_oe), .space_select_n(space_select_n), .rd_n(rd_n),
    .lane_strobe_n(lane_strobe_n), .ctrl_oe(ctrl_oe), .slow(slow), .data_in(data_in),
    .wait_n(wait_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    $display("[FAIL] t=%0t got %h exp %h", $time, 32'h0, 32'h1);
    test_done();
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  // One access; counts acks, refusals and start strobes until the port is idle again
  task automatic acc(input logic [28:0] a, input logic w, input logic [1:0] s,
                     input logic [31:0] d);
    acks = 0;
    errs = 0;
    starts = 0;
    lanes = 4'h0;
    sel_seen = 4'hf;
    dir_low = 1'b0;
    @(posedge clk);
    req <= 1'b1;
    req_addr <= a;
    req_we <= w;
    req_size <= s;
    req_wdata <= d;
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      req <= 1'b0;
      #1;
      if (req_ack === 1'b1) begin
        acks++;
        rdq = req_rdata;
      end
      if (req_err === 1'b1) errs++;
      if (cycle_start_strobe_n === 1'b0) starts++;
      if (data_oe === 1'b1) lanes |= ~lane_strobe_n;
      if (rdwr_n === 1'b0 && space_select_n !== 4'hf) dir_low = 1'b1;
      if (space_select_n !== 4'hf) sel_seen = space_select_n;
      if (req_ready === 1'b1 && acks + errs > 0) return;
    end
    timeout();
  endtask
  task automatic wait_on(input int k, input logic v, input int lim);
    logic s;
    for (int n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      s = (k == 0) ? bus_grant_out : (k == 1) ? bus_use_request_out : refresh_compare_match_irq;
      if (s === v) return;
    end
    timeout();
  endtask

  task automatic t_regs();
    rd(REG_SPACE0);
    chk({16'h0000, rv}, {16'h0000, CFG_RESET});
    rd(REG_MODE);
    chk({16'h0000, rv}, {16'h0000, MODE_RESET});
    rd(REG_COMPARE);
    chk({16'h0000, rv}, {16'h0000, COMPARE_RESET});
    rd(REG_STATUS);
    chk({16'h0000, rv & 16'h003e}, 32'h00000002);
    rd(5'h12);
    chk({16'h0000, rv}, 32'h00000000);
    $display("test registers done");
  endtask
  task automatic t_unconf();
    acc(29'h02000000, 1'b0, 2'h2, 32'h0);
    chk(errs, 1);
    chk(acks, 32'h0);
    chk(sel_seen, 4'hf);
    $display("test unconfigured space done");
  endtask
  task automatic t_basic();
    wr(REG_SPACE0, 16'h0010);
    acc(29'h10000100, 1'b1, 2'h2, 32'ha5c31e70);
    chk(starts, 1);
    chk(sel_seen, 4'he);
    chk(dir_low, 1'b1);
    chk(lanes, 4'hf);
    acc(29'h10000101, 1'b1, 2'h0, 32'h0000005a);
    chk(lanes, 4'h4);
    acc(29'h10000100, 1'b0, 2'h2, 32'h0);
    chk(rdq, 32'ha55a1e70);
    chk(dir_low, 1'b0);
    acc(29'h00000200, 1'b0, 2'h2, 32'h0);
    chk(acks, 4);
    chk(starts, 4);
    chk(rdq, 32'h0000020c);
    $display("test basic space 0 done");
  endtask
  task automatic t_wide();
    wr(5'h04, 16'h0008);
    slow <= 1'b1;
    acc(29'h12000040, 1'b1, 2'h2, 32'h12345678);
    chk(starts, 2);
    chk(lanes, 4'h3);
    chk(sel_seen, 4'hd);
    acc(29'h12000040, 1'b0, 2'h2, 32'h0);
    chk(rdq, 32'h12345678);
    slow <= 1'b0;
    $display("test 16-bit space done");
  endtask
  task automatic t_release();
    @(posedge clk);
    bus_release_request_in <= 1'b1;
    wait_on(0, 1'b1, 50);
    chk({addr_oe, ctrl_oe, data_oe}, 3'h0);
    @(posedge clk);
    bus_release_request_in <= 1'b0;
    wait_on(0, 1'b0, 50);
    $display("test bus release done");
  endtask
  task automatic t_slave();
    wr(REG_MODE, 16'h0002);
    fork
      acc(29'h10000100, 1'b0, 2'h2, 32'h0);
      begin
        wait_on(1, 1'b1, 50);
        repeat (3) @(posedge clk);
        chk(starts, 0);
        bus_use_enable_in <= 1'b1;
      end
    join
    chk(rdq, 32'ha55a1e70);
    wr(REG_MODE, 16'h0000);
    bus_use_enable_in <= 1'b0;
    $display("test slave mode done");
  endtask
  task automatic t_partial();
    wr(5'h08, 16'h0010);
    wr(REG_MODE, 16'h0001);
    acc(29'h10000100, 1'b0, 2'h2, 32'h0);
    chk(rdq, 32'ha55a1e70);
    fork
      acc(29'h14000100, 1'b1, 2'h2, 32'h0badcafe);
      begin
        wait_on(1, 1'b1, 50);
        @(posedge clk);
        bus_use_enable_in <= 1'b1;
      end
    join
    chk(sel_seen, 4'hb);
    wr(REG_MODE, 16'h0000);
    bus_use_enable_in <= 1'b0;
    $display("test partial-share mode done");
  endtask
  task automatic t_timer();
    wr(REG_COMPARE, 16'h0003);
    wr(REG_COUNT, 16'h0000);
    wr(REG_MODE, 16'h0044);
    wait_on(2, 1'b1, 2000);
    rd(REG_STATUS);
    chk(rv[0], 1'b1);
    wr(REG_MODE, 16'h0000);
    wait_on(2, 1'b0, 5);
    wr(REG_MODE, 16'h0008);
    #1;
    chk(cke, 1'b0);
    wr(REG_MODE, 16'h0000);
    $display("test refresh timer done");
  endtask

  initial begin
    err_total = 0;
    comparisons = 0;
    rstn = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req = 1'b0;
    req_addr = 29'h0;
    req_we = 1'b0;
    req_size = 2'h0;
    req_wdata = 32'h0;
    bus_release_request_in = 1'b0;
    bus_use_enable_in = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_unconf();
    t_basic();
    t_wide();
    t_release();
    t_slave();
    t_partial();
    t_timer();
    test_done();
  end
endmodule
